// >>> ddrs_ctrl.sv
// memory controller model driving the sram pins one cycle per cyc call
// assumes pins change on the falling edge; requests kept to positive slots
`timescale 1ns/1ps
`default_nettype none
module ddrs_ctrl import ddrs_pkg::*; (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  output var  ddrs_pins_t pins
);
  logic negPhase_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) negPhase_q <= 1'h0;
    else negPhase_q <= ~negPhase_q;
  end
  initial pins = '{DATA_RESET, 1'h1, 1'h1, 2'h3, ADDR_RESET};
  task automatic cyc(input logic r, w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [LANES-1:0] b);
    @(negedge clk);
    // low byte wired nibble-swapped: any bit order must store alike
    pins <= '{d, w, r, b, {a[ADDR_W-1:MEM_AW], a[MEM_AW/2-1:0], a[MEM_AW-1:MEM_AW/2]}};
  endtask : cyc
  // released lines show the inverse of their last value, with the low address byte nibble-swapped
  task automatic idle();
    cyc(1'h1, 1'h1, ~pins.addr, ~pins.wrData, ~pins.byteWriteSelectN);
  endtask : idle
  task automatic align();
    if (!negPhase_q) idle();
  endtask : align
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BURST-1:0][DATA_W-1:0] d,
                    input logic [BURST-1:0][LANES-1:0] b);
    align();
    cyc(1'h1, 1'h0, a, ~pins.wrData, 2'h3);
    for (int k = 0; k < BURST; k++) cyc(1'h1, 1'h1, ~a, d[k], b[k]);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    align();
    cyc(1'h0, 1'h1, a, ~pins.wrData, 2'h3);
    idle();
  endtask : rd
endmodule : ddrs_ctrl
`default_nettype wire

// >>> ddrs_fifo.sv
// parameterised valid/ready fifo
// assumes both sides on clk; full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module ddrs_fifo import ddrs_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [PW:0]   count;
  } ddrs_fifo_st_t;

  logic [WIDTH-1:0] store [DEPTH];
  ddrs_fifo_st_t    st_q;
  ddrs_fifo_st_t    st_d;
  logic             push;
  logic             pop;

  // full compare at the count's own width; a pointer-wide depth wraps to zero
  assign inReady  = (st_q.count != (PW+1)'(DEPTH));
  assign outValid = (st_q.count != '0);
  assign outData  = store[st_q.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wrPtr = (st_q.wrPtr == PW'(DEPTH-1)) ? '0 : st_q.wrPtr + PW'(1);
    end
    if (pop) begin
      st_d.rdPtr = (st_q.rdPtr == PW'(DEPTH-1)) ? '0 : st_q.rdPtr + PW'(1);
    end
    if (push && !pop) begin
      st_d.count = st_q.count + (PW+1)'(1);
    end else if (pop && !push) begin
      st_d.count = st_q.count - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[st_q.wrPtr] <= inData;
    end
  end
endmodule : ddrs_fifo
`default_nettype wire

// >>> ddrs_pkg.sv
// constants and carrier types of the burst sram pin front end
// assumes one 100 MHz clock, each clk edge standing for one input clock edge
// How it works
// - write data captured on every beat edge; the code drops beats that arrive while the fifo is full
// - low write select at positive edge starts write, unless read select is also low on that edge
// - write select high: no write, data ignored
// - byte selects sampled on each beat edge
// - deselected byte lane keeps stored contents
// - each select covers one nine-bit lane
// - byte select shares the edge of its beat
// - one shared address bus for reads and writes
// - four internal arrays, one per burst word
// - address ignored while its port deselected
// - read data driven on every beat edge
// - read outputs float when read port idle
// - low read select returns four-word burst
// - pending read completes before outputs float
// - valid flag marks beats carrying read data
package ddrs_pkg;
  localparam int DATA_W     = 18;
  localparam int ADDR_W     = 20;
  localparam int LANES      = 2;
  localparam int LANE_W     = 9;
  localparam int BURST      = 4;
  localparam int MEM_AW     = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [1:0]        BEAT_LAST  = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h0_0000;

  typedef enum logic [1:0] {
    DDRS_IDLE  = 2'b00,
    DDRS_BURST = 2'b01
  } ddrs_port_t;

  typedef struct packed {
    logic [DATA_W-1:0] wrData;
    logic              writePortSelectN;
    logic              readPortSelectN;
    logic [LANES-1:0]  byteWriteSelectN;
    logic [ADDR_W-1:0] addr;
  } ddrs_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0]        word;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  keepN;
  } ddrs_beat_t;

  localparam int BEAT_W = $bits(ddrs_beat_t);
endpackage : ddrs_pkg

// >>> ddrs_sram.sv
// device side of a separate-i/o four-word-burst ddr sram, 18-bit build
// assumes pins come from another domain and the controller aligns its
// positive clock edges to the cycles where the internal phase bit is zero
`timescale 1ns/1ps
`default_nettype none
module ddrs_sram import ddrs_pkg::*; (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [DATA_W-1:0] writeDataIn,
  input  wire logic              writePortSelectN,
  input  wire logic              readPortSelectN,
  input  wire logic [LANES-1:0]  byteWriteSelectN,
  input  wire logic [ADDR_W-1:0] addressIn,
  output var  logic [DATA_W-1:0] readDataOut,
  output var  logic              readDataOe,
  output var  logic              readValidFlag,
  output var  logic              writeStall
);
  typedef struct packed {
    ddrs_pins_t        pinS1;
    ddrs_pins_t        pinS2;
    logic              negPhase;
    ddrs_port_t        wrState;
    logic [1:0]        wrBeat;
    logic [ADDR_W-1:0] wrAddr;
    ddrs_port_t        rdState;
    logic [1:0]        rdBeat;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] q;
    logic              qOe;
    logic              qValid;
    logic              stall;
  } ddrs_st_t;

  ddrs_st_t          st_q;
  ddrs_st_t          st_d;
  logic [DATA_W-1:0] mem [BURST][2**MEM_AW];
  logic [DATA_W-1:0] rdWord;
  logic [DATA_W-1:0] oldWord;
  logic [DATA_W-1:0] mergedWord;
  ddrs_beat_t        beatIn;
  ddrs_beat_t        beatOut;
  logic              beatPush;
  logic              fifoReady;
  logic              beatValid;
  logic              drainReady;
  logic              wrStart;
  logic              rdStart;

  // positive-edge cycles sample the shared address bus
  assign rdStart = !st_q.negPhase && !st_q.pinS2.readPortSelectN;
  assign wrStart = !st_q.negPhase && !st_q.pinS2.writePortSelectN
                   && st_q.pinS2.readPortSelectN;

  always_comb begin
    st_d          = st_q;
    st_d.pinS1    = {writeDataIn, writePortSelectN, readPortSelectN,
                     byteWriteSelectN, addressIn};
    st_d.pinS2    = st_q.pinS1;
    st_d.negPhase = !st_q.negPhase;
    st_d.stall    = !fifoReady;
    beatPush      = 1'b0;
    beatIn.addr   = st_q.wrAddr;
    beatIn.word   = st_q.wrBeat;
    beatIn.data   = st_q.pinS2.wrData;
    beatIn.keepN  = st_q.pinS2.byteWriteSelectN;

    case (st_q.wrState)
      DDRS_IDLE: begin
        st_d.wrBeat = 2'h0;
      end
      DDRS_BURST: begin
        beatPush    = 1'b1;
        st_d.wrBeat = st_q.wrBeat + 2'h1;
        if (st_q.wrBeat == BEAT_LAST) begin
          st_d.wrState = DDRS_IDLE;
        end
      end
      default: begin
        st_d.wrState = DDRS_IDLE;
      end
    endcase
    // a new write can follow on the edge that carries the last beat
    if (wrStart && (st_q.wrState == DDRS_IDLE || st_q.wrBeat == BEAT_LAST)) begin
      st_d.wrState = DDRS_BURST;
      st_d.wrBeat  = 2'h0;
      st_d.wrAddr  = st_q.pinS2.addr;
    end // deselected: address and data left unsampled

    st_d.qValid = 1'b0;
    st_d.qOe    = 1'b0;
    case (st_q.rdState)
      DDRS_IDLE: begin
        st_d.rdBeat = 2'h0;
      end
      DDRS_BURST: begin
        st_d.q      = rdWord;
        st_d.qOe    = 1'b1;
        st_d.qValid = 1'b1;
        st_d.rdBeat = st_q.rdBeat + 2'h1;
        if (st_q.rdBeat == BEAT_LAST) begin
          st_d.rdState = DDRS_IDLE;
        end
      end
      default: begin
        st_d.rdState = DDRS_IDLE;
      end
    endcase
    if (rdStart && (st_q.rdState == DDRS_IDLE || st_q.rdBeat == BEAT_LAST)) begin
      st_d.rdState = DDRS_BURST;
      st_d.rdBeat  = 2'h0;
      st_d.rdAddr  = st_q.pinS2.addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '{pinS1: '1, pinS2: '1, negPhase: 1'b0, wrState: DDRS_IDLE,
                wrBeat: 2'h0, wrAddr: ADDR_RESET, rdState: DDRS_IDLE,
                rdBeat: 2'h0, rdAddr: ADDR_RESET, q: DATA_RESET,
                qOe: 1'b0, qValid: 1'b0, stall: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // bit order of the address is irrelevant to storage
  assign rdWord = mem[st_q.rdBeat][st_q.rdAddr[MEM_AW-1:0]];

  // writes drain only while no read burst uses the array; a read may
  // therefore miss a write still queued in the fifo
  assign drainReady = (st_q.rdState == DDRS_IDLE);

  ddrs_fifo #(
    .WIDTH (BEAT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_beats (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (beatPush),
    .inReady  (fifoReady),
    .inData   (beatIn),
    .outValid (beatValid),
    .outReady (drainReady),
    .outData  (beatOut)
  );

  assign oldWord = mem[beatOut.word][beatOut.addr[MEM_AW-1:0]];

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    // one nine-bit lane per select
    assign mergedWord[i*LANE_W +: LANE_W] = beatOut.keepN[i]
                                            ? oldWord[i*LANE_W +: LANE_W]
                                            : beatOut.data[i*LANE_W +: LANE_W];
  end

  always_ff @(posedge clk) begin
    if (beatValid && drainReady) begin
      mem[beatOut.word][beatOut.addr[MEM_AW-1:0]] <= mergedWord;
    end
  end

  assign readDataOut   = st_q.q;
  assign readDataOe    = st_q.qOe;
  assign readValidFlag = st_q.qValid;
  assign writeStall    = st_q.stall;
endmodule : ddrs_sram
`default_nettype wire

// >>> ddrs_sram_monitor.sv
// checker on the read burst and stall pins of ddrs_sram
// assumes requests sit on edges where the free-running phase bit is zero
`timescale 1ns/1ps
`default_nettype none
module ddrs_sram_monitor import ddrs_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic readPortSelectN,
  input wire logic readDataOe,
  input wire logic readValidFlag,
  input wire logic writeStall
);
  logic negPhase_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) negPhase_q <= 1'h0;
    else negPhase_q <= ~negPhase_q;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_flag_tracks_oe: assert property (readValidFlag == readDataOe)
    else $error("valid flag differs from enable");
  a_burst_four: assert property ($rose(readDataOe) |-> readDataOe[*4])
    else $error("burst shorter than four");
  a_burst_tail: assert property ($fell(readDataOe) |-> $past(readDataOe, 4))
    else $error("burst cut short");
  a_idle_float: assert property (readPortSelectN[*8] |-> !readDataOe)
    else $error("outputs driven while idle");
  a_read_latency: assert property ($fell(readPortSelectN) && !negPhase_q |->
    ##[2:4] readDataOe) else $error("read not answered");
  a_oe_cause: assert property ($rose(readDataOe) |-> !$past(readPortSelectN, 2) ||
    !$past(readPortSelectN, 3) || !$past(readPortSelectN, 4)) else $error("burst uncaused");
  a_neg_ignored: assert property (readPortSelectN[*4] ##1 (!readPortSelectN && negPhase_q)
    ##1 readPortSelectN[*6] |-> !readDataOe) else $error("negative slot read taken");
  // fifo drains whenever no read burst runs, so only reads can fill it
  a_stall_cause: assert property ($rose(writeStall) |-> $past(readDataOe) ||
    $past(readDataOe, 2) || $past(readDataOe, 3)) else $error("stall without reads");
endmodule : ddrs_sram_monitor
bind ddrs_sram ddrs_sram_monitor ddrs_sram_monitor_i (.clk, .sys_rst, .readPortSelectN,
  .readDataOe, .readValidFlag, .writeStall);
`default_nettype wire

// >>> tb_ddrs_sram.sv
// self-checking bench for ddrs_sram behind a controller model
// assumes the model keeps requests on positive slots
`timescale 1ns/1ps
`default_nettype none
module tb_ddrs_sram import ddrs_pkg::*;;
  logic              clk;
  logic              sys_rst;
  ddrs_pins_t        pins;
  logic [DATA_W-1:0] readDataOut;
  logic              readDataOe;
  logic              readValidFlag;
  logic              writeStall;
  logic              sawStall;
  int                err_count = 0;
  int                comparisons = 0;
  logic [DATA_W-1:0] mem [BURST][2**MEM_AW];
  ddrs_ctrl ddrs_ctrl_i (.clk, .sys_rst, .pins);
  ddrs_sram ddrs_sram_i (.clk, .sys_rst, .writeDataIn(pins.wrData),
    .writePortSelectN(pins.writePortSelectN), .readPortSelectN(pins.readPortSelectN),
    .byteWriteSelectN(pins.byteWriteSelectN), .addressIn(pins.addr), .readDataOut,
    .readDataOe, .readValidFlag, .writeStall);
  always @(negedge clk) if (writeStall === 1'h1) sawStall = 1'h1;
  task automatic chk(input string what, input logic [DATA_W-1:0] e, s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wrExp(input logic [ADDR_W-1:0] a, input logic [BURST-1:0][DATA_W-1:0] d,
                       input logic [BURST-1:0][LANES-1:0] b);
    for (int k = 0; k < BURST; k++)
      for (int l = 0; l < LANES; l++)
        if (!b[k][l]) mem[k][a[MEM_AW-1:0]][l*LANE_W +: LANE_W] = d[k][l*LANE_W +: LANE_W];
    ddrs_ctrl_i.wr(a, d, b);
    // reads do not see beats still queued
    repeat (8) ddrs_ctrl_i.idle();
  endtask : wrExp
  task automatic rdChk(input logic [1:0][ADDR_W-1:0] a, input int n);
    fork
      for (int i = 0; i < n; i++) begin
        ddrs_ctrl_i.rd(a[i]);
        repeat (2) ddrs_ctrl_i.idle();
      end
      begin
        for (int t = 0; t < 12 && readValidFlag !== 1'h1; t++) @(negedge clk);
        for (int i = 0; i < 4 * n; i++) begin
          chk("read word", mem[i % 4][a[i / 4][MEM_AW-1:0]], readDataOut);
          chk("burst enable", 1'h1, readDataOe);
          @(negedge clk);
        end
        chk("idle enable", 1'h0, readDataOe);
      end
    join
  endtask : rdChk
  task automatic t_basic();
    wrExp(20'h0_0001, {18'h1_1111, 18'h2_2222, 18'h3_3333, 18'h0_4444}, '0);
    rdChk({20'h0_0001, 20'h0_0001}, 1);
    $display("basic done");
  endtask : t_basic
  task automatic t_lanes();
    wrExp(20'h0_0002, '0, '0);
    wrExp(20'h0_0002, {4{18'h2_AAAA}}, {2'h3, 2'h2, 2'h1, 2'h0});
    rdChk({20'h0_0002, 20'h0_0001}, 2);
    $display("lanes done");
  endtask : t_lanes
  task automatic t_desel();
    repeat (6) ddrs_ctrl_i.cyc(1'h1, 1'h1, 20'h0_0001, 18'h3_FFFF, 2'h0);
    ddrs_ctrl_i.align();
    ddrs_ctrl_i.idle();
    ddrs_ctrl_i.cyc(1'h0, 1'h1, 20'h0_0001, 18'h3_FFFF, 2'h0);
    repeat (8) ddrs_ctrl_i.idle();
    rdChk({20'h0_0001, 20'h0_0001}, 1);
    $display("deselect done");
  endtask : t_desel
  task automatic t_fill();
    sawStall = 1'h0;
    ddrs_ctrl_i.align();
    for (int i = 0; i < 4; i++)
      for (int c = 0; c < 4; c++)
        ddrs_ctrl_i.cyc(c != 0, c != 2, {19'h0_0000, c[1]}, 18'h1_2345, 2'h0);
    repeat (4) ddrs_ctrl_i.cyc(1'h1, 1'h1, 20'h0_0000, 18'h1_2345, 2'h0);
    for (int k = 0; k < BURST; k++) mem[k][1] = 18'h1_2345;
    chk("stall seen", 1'h1, sawStall);
    repeat (20) ddrs_ctrl_i.idle();
    chk("stall clear", 1'h0, writeStall);
    rdChk({20'h0_0001, 20'h0_0001}, 1);
    $display("fill done");
  endtask : t_fill
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    sys_rst = 1'h1;
    repeat (3) @(negedge clk);
    sys_rst = 1'h0;
    ddrs_ctrl_i.idle();
    t_basic();
    t_lanes();
    t_desel();
    t_fill();
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule : tb_ddrs_sram
`default_nettype wire
